// ===== spio_port.sv
// shared parallel io port: data latch, direction and pull registers, pin sync and drive
// assumes a 250 MHz bus clock, synchronous inputs and an outside pad that resolves enables
`timescale 1ns/100ps
`include "spio_params.svh"

module spio_port
    import spio_pkg::*;
#(
    parameter bit LARGE_PKG = 1'b1
) (
    // clock, reset, enable
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // register access
    input wire logic [`SPIO_ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [`SPIO_PIN_W-1:0] reg_wdata_i,
    output logic [`SPIO_PIN_W-1:0] reg_rdata_o,
    // shared peripheral functions
    input wire logic [`SPIO_PIN_W-1:0] dig_en_i,
    input wire logic [`SPIO_PIN_W-1:0] dig_oe_i,
    input wire logic [`SPIO_PIN_W-1:0] dig_do_i,
    input wire logic [`SPIO_PIN_W-1:0] ana_en_i,
    input wire logic bdm_release_i,
    input wire logic bdm_oe_i,
    input wire logic bdm_do_i,
    // pins
    input wire logic [`SPIO_PIN_W-1:0] pin_in_i,
    output logic [`SPIO_PIN_W-1:0] pin_out_o,
    output logic [`SPIO_PIN_W-1:0] pin_oe_n_o,
    output logic [`SPIO_PIN_W-1:0] pin_pull_en_o,
    output logic [`SPIO_PIN_W-1:0] pin_ibuf_en_o,
    output logic [`SPIO_PIN_W-1:0] pin_sync_o,
    output logic bdm_sel_o
);
    // pin count follows the package; pins that are absent are never driven or pulled
    localparam spio_pins_t BIDIR_MASK = LARGE_PKG ? `SPIO_BIDIR_LARGE : `SPIO_BIDIR_SMALL;
    localparam spio_pins_t PULL_MASK = BIDIR_MASK | `SPIO_IN_ONLY_MASK;

    spio_pins_t latch_r;
    spio_pins_t dir_r;
    spio_pins_t pull_r;
    logic bdm_sel_r;
    spio_pins_t sync1_r;
    spio_pins_t sync2_r;
    spio_pins_t pin_out_r;
    spio_pins_t pin_oe_n_r;
    spio_pins_t pin_pull_r;
    spio_pins_t pin_ibuf_r;
    spio_pins_t rdata_r;
    spio_pins_t rdata_nxt;
    logic wr_data;
    logic wr_dir;
    logic wr_pull;

    // the buffer mux sees only this bundle, never the raw ports
    spio_mux_if mx ();

    // short addressing reaches every register: the address port is only 5 bits wide
    assign wr_data = reg_wr_i && (reg_addr_i == `SPIO_ADDR_DATA);
    assign wr_dir = reg_wr_i && (reg_addr_i == `SPIO_ADDR_DIR);
    assign wr_pull = reg_wr_i && (reg_addr_i == `SPIO_ADDR_PULL);

    // all state freezes with ce_i low; nothing is cleared by low-power entry,
    // so the pins and their functions come back exactly as they were
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            latch_r <= `SPIO_DATA_RST;
        end else if (ce_i && wr_data) begin
            latch_r <= reg_wdata_i;
        end
    end

    // unimplemented direction bits stay zero
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            dir_r <= `SPIO_DIR_RST;
        end else if (ce_i && wr_dir) begin
            dir_r <= reg_wdata_i & BIDIR_MASK;
        end
    end

    // pull bits exist only on pins that can be inputs
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pull_r <= `SPIO_PULL_RST;
        end else if (ce_i && wr_pull) begin
            pull_r <= reg_wdata_i & PULL_MASK;
        end
    end

    // debug ownership of the output-only pin is given up once and only reset returns it
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            bdm_sel_r <= `SPIO_BDM_SEL_RST;
        end else if (ce_i && bdm_release_i) begin
            bdm_sel_r <= 1'b0;
        end
    end

    // first stage feeds the second stage only
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            sync1_r <= `SPIO_ZERO;
        end else if (ce_i) begin
            sync1_r <= pin_in_i;
        end
    end

    // only this stage is read, so a settling first stage never reaches the read mux
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            sync2_r <= `SPIO_ZERO;
        end else if (ce_i) begin
            sync2_r <= sync1_r;
        end
    end

    assign mx.latch = latch_r;
    assign mx.dir = dir_r;
    assign mx.pull_en = pull_r;
    assign mx.pin_sync = sync2_r;
    // peripheral requests are ignored during reset so the port owns every pin but the output-only one, which debug holds
    assign mx.dig_en = sys_rst_i ? `SPIO_ZERO : dig_en_i;
    assign mx.ana_en = sys_rst_i ? `SPIO_ZERO : ana_en_i;
    // enables and data pass untouched; ownership, pin presence and the input-only bit decide whether they reach a pin
    assign mx.dig_oe = dig_oe_i;
    assign mx.dig_do = dig_do_i;
    assign mx.bdm_sel = bdm_sel_r;
    assign mx.bdm_oe = bdm_oe_i;
    assign mx.bdm_do = bdm_do_i;

    spio_pin_mux #(
        .BIDIR_MASK(BIDIR_MASK)
    ) u_mux (
        .m(mx.mux)
    );

    // pin controls are registered: one cycle of latency buys glitch-free pad enables
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pin_oe_n_r <= `SPIO_ALL_ONES;
        end else if (ce_i) begin
            pin_oe_n_r <= ~mx.oe;
        end
    end

    // latched zeros sit behind disabled drivers until a direction bit is set; the output-only pin has none and drives once debug lets go
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pin_out_r <= `SPIO_ZERO;
        end else if (ce_i) begin
            pin_out_r <= mx.dout;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pin_pull_r <= `SPIO_ZERO;
        end else if (ce_i) begin
            pin_pull_r <= mx.pull_on;
        end
    end

    // input buffers come on at the first live edge after reset
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pin_ibuf_r <= `SPIO_ZERO;
        end else if (ce_i) begin
            pin_ibuf_r <= mx.ibuf_en;
        end
    end

    // unmapped addresses read as zero rather than whatever was last selected
    always_comb begin
        case (reg_addr_i)
            `SPIO_ADDR_DATA: rdata_nxt = mx.rd_bits;
            `SPIO_ADDR_DIR: rdata_nxt = dir_r;
            `SPIO_ADDR_PULL: rdata_nxt = pull_r;
            default: rdata_nxt = `SPIO_ZERO;
        endcase
    end

    // read data appears the edge after reg_rd_i and holds until the next read
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rdata_r <= `SPIO_ZERO;
        end else if (ce_i && reg_rd_i) begin
            rdata_r <= rdata_nxt;
        end
    end

    // every output comes straight from a flop
    assign reg_rdata_o = rdata_r;
    assign pin_out_o = pin_out_r;
    assign pin_oe_n_o = pin_oe_n_r;
    assign pin_pull_en_o = pin_pull_r;
    assign pin_ibuf_en_o = pin_ibuf_r;
    assign pin_sync_o = sync2_r;
    assign bdm_sel_o = bdm_sel_r;
endmodule // spio_port

// ===== spio_params.svh
// constants for the shared parallel io port: pin map, register addresses, reset values
// assumes inclusion by bare name from every file that needs them
`ifndef SPIO_PARAMS_SVH
`define SPIO_PARAMS_SVH

`define SPIO_PIN_W 6
`define SPIO_IN_ONLY_BIT 2
`define SPIO_OUT_ONLY_BIT 3
`define SPIO_BIDIR_LARGE 6'h33
`define SPIO_BIDIR_SMALL 6'h03
`define SPIO_IN_ONLY_MASK 6'h04
`define SPIO_OUT_ONLY_MASK 6'h08
`define SPIO_ADDR_W 5
`define SPIO_ADDR_DATA 5'h00
`define SPIO_ADDR_DIR 5'h01
`define SPIO_ADDR_PULL 5'h02
`define SPIO_DATA_RST 6'h00
`define SPIO_DIR_RST 6'h00
`define SPIO_PULL_RST 6'h00
`define SPIO_BDM_SEL_RST 1'b1
`define SPIO_ZERO 6'h00
`define SPIO_ALL_ONES 6'h3f

`endif

// ===== spio_pkg.sv
// types shared by the port's modules
// assumes spio_params.svh gives the pin width
`include "spio_params.svh"

package spio_pkg;
    typedef logic [`SPIO_PIN_W-1:0] spio_pins_t;
    // who owns a pin's buffers
    typedef enum logic [1:0] {
        SPIO_OWN_PORT = 2'b00,
        SPIO_OWN_DIG = 2'b01,
        SPIO_OWN_ANA = 2'b10,
        SPIO_OWN_BDM = 2'b11
    } spio_owner_t;
endpackage

// ===== spio_mux_if.sv
// signals between the port's register side and its per-pin buffer mux
// assumes both ends share one clock; the mux is purely combinational
`timescale 1ns/100ps

interface spio_mux_if;
    import spio_pkg::*;
    spio_pins_t latch;
    spio_pins_t dir;
    spio_pins_t pull_en;
    spio_pins_t pin_sync;
    spio_pins_t dig_en;
    spio_pins_t dig_oe;
    spio_pins_t dig_do;
    spio_pins_t ana_en;
    logic bdm_sel;
    logic bdm_oe;
    logic bdm_do;
    spio_pins_t oe;
    spio_pins_t dout;
    spio_pins_t ibuf_en;
    spio_pins_t pull_on;
    spio_pins_t rd_bits;
    modport ctl (output latch, dir, pull_en, pin_sync, dig_en, dig_oe, dig_do, ana_en,
                 output bdm_sel, bdm_oe, bdm_do,
                 input oe, dout, ibuf_en, pull_on, rd_bits);
    modport mux (input latch, dir, pull_en, pin_sync, dig_en, dig_oe, dig_do, ana_en,
                 input bdm_sel, bdm_oe, bdm_do,
                 output oe, dout, ibuf_en, pull_on, rd_bits);
endinterface

// ===== spio_pin_mux.sv
// per-pin ownership and buffer control for the shared port
// assumes the caller registers every result before it reaches a pin
`timescale 1ns/100ps
`include "spio_params.svh"

module spio_pin_mux
    import spio_pkg::*;
#(
    parameter spio_pins_t BIDIR_MASK = `SPIO_BIDIR_LARGE
) (
    spio_mux_if.mux m
);
    localparam spio_pins_t PRESENT = BIDIR_MASK | `SPIO_IN_ONLY_MASK | `SPIO_OUT_ONLY_MASK;

    genvar i;
    generate
        for (i = 0; i < `SPIO_PIN_W; i = i + 1) begin : g_pin
            spio_owner_t owner;
            logic dir_eff;
            always_comb begin
                if (i == `SPIO_OUT_ONLY_BIT && m.bdm_sel) begin
                    owner = SPIO_OWN_BDM;
                end else if (m.ana_en[i]) begin
                    owner = SPIO_OWN_ANA;
                end else if (m.dig_en[i]) begin
                    owner = SPIO_OWN_DIG;
                end else begin
                    owner = SPIO_OWN_PORT;
                end
                // input-only never drives, output-only always drives when the port owns it
                if (i == `SPIO_OUT_ONLY_BIT) begin
                    dir_eff = 1'b1;
                end else if (BIDIR_MASK[i]) begin
                    dir_eff = m.dir[i];
                end else begin
                    dir_eff = 1'b0;
                end
                case (owner)
                    SPIO_OWN_PORT: begin
                        m.oe[i] = dir_eff && PRESENT[i];
                        m.dout[i] = m.latch[i];
                    end
                    SPIO_OWN_DIG: begin
                        m.oe[i] = m.dig_oe[i] && PRESENT[i] && (i != `SPIO_IN_ONLY_BIT);
                        m.dout[i] = m.dig_do[i];
                    end
                    SPIO_OWN_ANA: begin
                        m.oe[i] = 1'b0;
                        m.dout[i] = 1'b0;
                    end
                    SPIO_OWN_BDM: begin
                        m.oe[i] = m.bdm_oe;
                        m.dout[i] = m.bdm_do;
                    end
                    default: begin
                        m.oe[i] = 1'b0;
                        m.dout[i] = 1'b0;
                    end
                endcase
                m.ibuf_en[i] = PRESENT[i] && !m.ana_en[i] && (i != `SPIO_OUT_ONLY_BIT);
                m.pull_on[i] = m.pull_en[i] && !m.oe[i] && !m.ana_en[i]
                    && (BIDIR_MASK[i] || i == `SPIO_IN_ONLY_BIT);
                // read source follows the direction bit even when a peripheral drives
                if (dir_eff) begin
                    m.rd_bits[i] = m.latch[i];
                end else begin
                    m.rd_bits[i] = m.ibuf_en[i] && m.pin_sync[i];
                end
            end
        end
    endgenerate
endmodule // spio_pin_mux

// ===== spio_pad_model.sv
// pad model for the shared port: resolves each pin from the port drive and the board
// assumes the board drives every pin that the port leaves undriven
`timescale 1ns/100ps
module spio_pad_model
    import spio_pkg::*;
(
    // port side
    input wire spio_pins_t pin_out_i,
    input wire spio_pins_t pin_oe_n_i,
    // board side
    input wire spio_pins_t ext_val_i,
    // resolved level
    output spio_pins_t pin_lvl_o
);
    // the port wins where it drives; the board only fills in released pins
    assign pin_lvl_o = (~pin_oe_n_i & pin_out_i) | (pin_oe_n_i & ext_val_i);
endmodule // spio_pad_model

// ===== spio_port_checker.sv
// assertions on the shared port's pins, read data and debug ownership
// assumes the large package pin map and a bind from the bench
`timescale 1ns/100ps
module spio_port_checker
    import spio_pkg::*;
(
    // clock, reset, enable
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // register access
    input wire logic reg_rd_i,
    input wire spio_pins_t reg_rdata_o,
    // shared functions
    input wire spio_pins_t dig_en_i,
    input wire spio_pins_t dig_oe_i,
    input wire spio_pins_t dig_do_i,
    input wire spio_pins_t ana_en_i,
    input wire logic bdm_oe_i,
    // pins
    input wire spio_pins_t pin_in_i,
    input wire spio_pins_t pin_out_o,
    input wire spio_pins_t pin_oe_n_o,
    input wire spio_pins_t pin_pull_en_o,
    input wire spio_pins_t pin_ibuf_en_o,
    input wire spio_pins_t pin_sync_o,
    input wire logic bdm_sel_o
);
    // outputs lag their controls by one edge, so gate on the previous edge being live
    // both flags start unknown, which keeps the very first edge vacuous
    logic run_r;
    logic rst_d_r;
    always_ff @(posedge sys_clk_i) begin
        run_r <= ce_i && !sys_rst_i;
        rst_d_r <= ce_i && sys_rst_i;
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_analog_bufs_off: assert property (run_r |-> ((pin_ibuf_en_o | ~pin_oe_n_o
        | pin_pull_en_o) & $past(ana_en_i) & 6'h37) == 6'h00) else $error("analog pin buffered");
    a_digital_owns_oe: assert property (run_r |-> ((~pin_oe_n_o ^ $past(dig_oe_i))
        & $past(dig_en_i & ~ana_en_i) & 6'h33) == 6'h00) else $error("digital oe lost");
    a_digital_data: assert property (run_r |-> ((pin_out_o ^ $past(dig_do_i))
        & $past(dig_en_i & dig_oe_i & ~ana_en_i) & 6'h33) == 6'h00) else $error("digital data");
    a_ibuf_enable: assert property (run_r |-> pin_ibuf_en_o == (~$past(ana_en_i) & 6'h37))
        else $error("input buffer wrong");
    a_pull_off_drive: assert property ((pin_pull_en_o & ~pin_oe_n_o) == 6'h00)
        else $error("pull on driven pin");
    a_reset_values: assert property (disable iff (1'b0) rst_d_r |->
        pin_oe_n_o == 6'h3f && pin_pull_en_o == 6'h00 && bdm_sel_o && reg_rdata_o == 6'h00)
        else $error("reset state wrong");
    a_rdata_hold: assert property (run_r && !$past(reg_rd_i) |-> $stable(reg_rdata_o))
        else $error("read data moved");
    a_sync_stages: assert property (run_r && $past(run_r) |-> (pin_sync_o & 6'h37) ==
        ($past(pin_in_i, 2) & 6'h37)) else $error("sync depth wrong");
    a_debug_pin: assert property (run_r && $past(bdm_sel_o) && bdm_sel_o |->
        pin_oe_n_o[3] == !$past(bdm_oe_i)) else $error("debug pin drive wrong");
endmodule // spio_port_checker

// ===== tb_shared_parallel_io_port.sv
// bench for the shared port: table of pin setups, then map, hold and reset cases
// assumes the pad model fills every pin the port leaves undriven
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module tb_shared_parallel_io_port;
    import spio_pkg::*;
    typedef struct packed {
        spio_pins_t dir, dat, ext, den, doe, ddo, ana, oe_n, out, rd;
    } spio_row_t;
    localparam spio_row_t ROWS [6] = '{
        '{6'h33, 6'h2a, 6'h3f, 6'h00, 6'h00, 6'h00, 6'h00, 6'h04, 6'h2a, 6'h2e},
        '{6'h00, 6'h15, 6'h36, 6'h00, 6'h00, 6'h00, 6'h00, 6'h37, 6'h00, 6'h36},
        '{6'h00, 6'h00, 6'h3f, 6'h03, 6'h01, 6'h01, 6'h00, 6'h36, 6'h01, 6'h37},
        '{6'h03, 6'h00, 6'h3f, 6'h03, 6'h03, 6'h03, 6'h00, 6'h34, 6'h03, 6'h34},
        '{6'h00, 6'h00, 6'h3f, 6'h30, 6'h30, 6'h30, 6'h31, 6'h37, 6'h00, 6'h06},
        '{6'h33, 6'h3f, 6'h00, 6'h00, 6'h00, 6'h00, 6'h33, 6'h37, 6'h08, 6'h3b}};
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [4:0] reg_addr_i = 5'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic bdm_release_i = 1'b0;
    logic bdm_oe_i = 1'b1;
    logic bdm_do_i = 1'b1;
    logic bdm_sel_o;
    spio_pins_t reg_wdata_i = 6'h00, dig_en_i = 6'h00, dig_oe_i = 6'h00, dig_do_i = 6'h00;
    spio_pins_t ana_en_i = 6'h00, ext_val = 6'h00, snap;
    spio_pins_t reg_rdata_o, pin_in_i, pin_out_o, pin_oe_n_o, pin_pull_en_o, pin_ibuf_en_o;
    spio_pins_t pin_sync_o;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    spio_row_t r;

    spio_port dut_u (.sys_clk_i, .sys_rst_i, .ce_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
        .reg_wdata_i, .reg_rdata_o, .dig_en_i, .dig_oe_i, .dig_do_i, .ana_en_i,
        .bdm_release_i, .bdm_oe_i, .bdm_do_i, .pin_in_i, .pin_out_o, .pin_oe_n_o,
        .pin_pull_en_o, .pin_ibuf_en_o, .pin_sync_o, .bdm_sel_o);
    spio_pad_model pad_u (.pin_out_i(pin_out_o), .pin_oe_n_i(pin_oe_n_o), .ext_val_i(ext_val),
        .pin_lvl_o(pin_in_i));

    always #2 sys_clk_i = ~sys_clk_i;

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // the whole run is a little over a hundred cycles, so this only trips on a hang
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            end_sim();
        end
    end

    // one register access: strobe for one edge, result settled just after it
    task automatic acc(input logic [4:0] a, input logic w, input spio_pins_t d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= w;
        reg_rd_i <= !w;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        #1;
    endtask

    initial begin
        repeat (4) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        #1;
        `CHK(pin_oe_n_o, 6'h37)
        `CHK(pin_out_o[3], 1'b1)
        @(posedge sys_clk_i);
        bdm_release_i <= 1'b1;
        acc(5'h02, 1'b1, 6'h3f);
        @(posedge sys_clk_i);
        bdm_release_i <= 1'b0;
        acc(5'h02, 1'b0, 6'h00);
        `CHK(reg_rdata_o, 6'h37)
        $display("startup test done");
        foreach (ROWS[i]) begin
            r = ROWS[i];
            // data goes in before direction so no stale level is driven
            acc(5'h00, 1'b1, r.dat);
            acc(5'h01, 1'b1, r.dir);
            @(posedge sys_clk_i);
            dig_en_i <= r.den;
            dig_oe_i <= r.doe;
            dig_do_i <= r.ddo;
            ana_en_i <= r.ana;
            ext_val <= r.ext;
            repeat (5) @(posedge sys_clk_i);
            #1;
            `CHK(pin_oe_n_o, r.oe_n)
            `CHK(pin_out_o & ~pin_oe_n_o, r.out)
            `CHK(pin_ibuf_en_o, ~r.ana & 6'h37)
            `CHK(pin_pull_en_o, 6'h37 & ~r.ana & r.oe_n)
            `CHK(pin_sync_o, (~r.oe_n & r.out) | (r.oe_n & r.ext))
            acc(5'h00, 1'b0, 6'h00);
            `CHK(reg_rdata_o, r.rd)
            $display("row %0d done", i);
        end
        acc(5'h1f, 1'b1, 6'h3f);
        acc(5'h1f, 1'b0, 6'h00);
        `CHK(reg_rdata_o, 6'h00)
        acc(5'h01, 1'b1, 6'h3f);
        acc(5'h01, 1'b0, 6'h00);
        `CHK(reg_rdata_o, 6'h33)
        $display("map test done");
        // frozen clock enable stands in for wait and stop: nothing may move
        snap = pin_oe_n_o;
        @(posedge sys_clk_i);
        ce_i <= 1'b0;
        ana_en_i <= 6'h00;
        reg_wr_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        #1;
        `CHK(pin_oe_n_o, snap)
        @(posedge sys_clk_i);
        ana_en_i <= 6'h33;
        reg_wr_i <= 1'b0;
        ce_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        #1;
        `CHK(pin_oe_n_o, snap)
        acc(5'h01, 1'b0, 6'h00);
        `CHK(reg_rdata_o, 6'h33)
        $display("hold test done");
        @(posedge sys_clk_i);
        sys_rst_i <= 1'b1;
        bdm_oe_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        acc(5'h01, 1'b0, 6'h00);
        `CHK(reg_rdata_o, 6'h00)
        `CHK(bdm_sel_o, 1'b1)
        `CHK(pin_oe_n_o, 6'h3f)
        acc(5'h02, 1'b0, 6'h00);
        `CHK(reg_rdata_o, 6'h00)
        acc(5'h01, 1'b1, 6'h33);
        acc(5'h00, 1'b0, 6'h00);
        `CHK(reg_rdata_o, 6'h00)
        $display("reset test done");
        end_sim();
    end
endmodule // tb_shared_parallel_io_port

bind spio_port spio_port_checker chk_u (.sys_clk_i, .sys_rst_i, .ce_i, .reg_rd_i, .reg_rdata_o,
    .dig_en_i, .dig_oe_i, .dig_do_i, .ana_en_i, .bdm_oe_i, .pin_in_i, .pin_out_o, .pin_oe_n_o,
    .pin_pull_en_o, .pin_ibuf_en_o, .pin_sync_o, .bdm_sel_o);
